// [ddr2_write_burst.sv]
// The implementer's own choices: the strobed register port and the placing of the registers.
module ddr2_write_burst
    import ddr2_write_burst_pkg::*;
#(
    parameter int DATA_WIDTH = 8,
    parameter int BANK_WIDTH = 3,
    parameter int COL_WIDTH  = 10
) (
    // Clock and reset
    input  wire logic                                  CLK_IN,
    input  wire logic                                  SYS_RST_IN,
    // Register port
    input  wire logic [ddr2_write_burst_pkg::REG_ADDR_WIDTH-1:0] REG_ADDR_IN,
    input  wire logic [ddr2_write_burst_pkg::REG_DATA_WIDTH-1:0] REG_WDATA_IN,
    input  wire logic                                  REG_WR_IN,
    input  wire logic                                  REG_RD_IN,
    output logic [ddr2_write_burst_pkg::REG_DATA_WIDTH-1:0]      REG_RDATA_OUT,
    // Memory pins
    input  wire logic                                  CK_IN,
    input  wire logic                                  WRITE_CMD_IN,
    input  wire logic                                  AUTO_PRECHARGE_IN,
    input  wire logic [BANK_WIDTH-1:0]                 BANK_IN,
    input  wire logic [COL_WIDTH-1:0]                  COLUMN_IN,
    input  wire logic                                  STROBE_IN,
    input  wire logic [DATA_WIDTH-1:0]                 DQ_IN,
    output logic [DATA_WIDTH-1:0]                      DQ_OUT,
    output logic                                       DQ_OE_OUT,
    // Captured data to the array
    output logic [DATA_WIDTH-1:0]                      DATA_OUT,
    output logic                                       DATA_VALID_OUT,
    output logic [BANK_WIDTH-1:0]                      DATA_BANK_OUT,
    output logic [COL_WIDTH-1:0]                       DATA_COLUMN_OUT,
    // Row close request
    output logic                                       ROW_CLOSE_OUT,
    output logic [BANK_WIDTH-1:0]                      ROW_CLOSE_BANK_OUT
);

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        logic [2:0]                  ck_s;
        logic [2:0]                  strobe_s;
        logic [1:0]                  cmd_s;
        logic [1:0]                  ap_s;
        logic [1:0][BANK_WIDTH-1:0]  bank_s;
        logic [1:0][COL_WIDTH-1:0]   col_s;
        logic [1:0][DATA_WIDTH-1:0]  dq_s;
        logic [2:0]                  cas_latency;
        logic                        burst_length8;
        logic [2:0]                  recovery_setting_field;
        logic                        active;
        logic [BANK_WIDTH-1:0]       cur_bank;
        logic [COL_WIDTH-1:0]        cur_col;
        logic                        cur_ap;
        logic                        cur_len8;
        logic [3:0]                  elem;
        logic [2:0]                  wl_cnt;
        logic [2:0]                  since_cmd;
        logic                        pend;
        logic [BANK_WIDTH-1:0]       pend_bank;
        logic [COL_WIDTH-1:0]        pend_col;
        logic                        pend_ap;
        logic                        pend_len8;
        logic                        trunc;
        logic                        pre_run;
        logic [2:0]                  pre_cnt;
        logic [BANK_WIDTH-1:0]       pre_bank;
        logic                        close;
        logic [BANK_WIDTH-1:0]       close_bank;
        logic [DATA_WIDTH-1:0]       data;
        logic                        data_valid;
        logic [BANK_WIDTH-1:0]       data_bank;
        logic [COL_WIDTH-1:0]        data_col;
        logic [DATA_WIDTH-1:0]       last_data;
        logic [15:0]                 cap_count;
        logic [REG_DATA_WIDTH-1:0]   rdata;
    } state_type;

    state_type state_reg;
    state_type state_next;

    logic       ck_rise;
    logic       strobe_rise;
    logic       strobe_fall;
    logic [2:0] write_latency;
    logic [3:0] burst_len;
    logic       take_elem;
    logic       burst_end;

    // --------------------------------------------------------------
    // Edge detection on synchronised pins
    // --------------------------------------------------------------
    // Strobe and CK share equal synchroniser depth, so their order holds
    assign ck_rise     = state_reg.ck_s[1] & ~state_reg.ck_s[2];
    assign strobe_rise = state_reg.strobe_s[1] & ~state_reg.strobe_s[2];
    assign strobe_fall = ~state_reg.strobe_s[1] & state_reg.strobe_s[2];
    assign write_latency = state_reg.cas_latency - WRITE_LAT_DELTA;
    assign burst_len = state_reg.cur_len8 ? BURST_LONG : BURST_SHORT;

    // First element needs a rising edge, later ones take both edges
    assign take_elem = state_reg.active && state_reg.wl_cnt == 3'h0 &&
        (strobe_rise || (state_reg.elem != 4'h0 && strobe_fall));

    // A cut happens only at the prefetch boundary of a flagged burst
    assign burst_end = take_elem &&
        ((state_reg.elem + 4'h1 == burst_len) ||
         (state_reg.trunc &&
          state_reg.elem + 4'h1 == PREFETCH_ELEMS));

    // Write-only block: data pins never driven
    assign DQ_OUT    = '0;
    assign DQ_OE_OUT = 1'b0;

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.ck_s     = {state_reg.ck_s[1:0], CK_IN};
        state_next.strobe_s = {state_reg.strobe_s[1:0], STROBE_IN};
        state_next.cmd_s    = {state_reg.cmd_s[0], WRITE_CMD_IN};
        state_next.ap_s     = {state_reg.ap_s[0], AUTO_PRECHARGE_IN};
        state_next.bank_s   = {state_reg.bank_s[0], BANK_IN};
        state_next.col_s    = {state_reg.col_s[0], COLUMN_IN};
        state_next.dq_s     = {state_reg.dq_s[0], DQ_IN};
        state_next.data_valid = 1'b0;
        state_next.close      = 1'b0;

        // Preamble window opens one CK early so an early strobe is kept
        if (ck_rise && state_reg.wl_cnt != 3'h0) begin
            state_next.wl_cnt = state_reg.wl_cnt - 3'h1;
        end
        if (ck_rise && state_reg.since_cmd != 3'h7) begin
            state_next.since_cmd = state_reg.since_cmd + 3'h1;
        end

        // Data capture
        if (take_elem) begin
            state_next.data       = state_reg.dq_s[1];
            state_next.data_valid = 1'b1;
            state_next.data_bank  = state_reg.cur_bank;
            state_next.data_col   = state_reg.cur_col +
                COL_WIDTH'(state_reg.elem);
            state_next.last_data  = state_reg.dq_s[1];
            state_next.cap_count  = state_reg.cap_count + 16'h1;
            state_next.elem       = state_reg.elem + 4'h1;
        end

        // Burst end: hand over to a queued write or go idle
        if (burst_end) begin
            if (state_reg.cur_ap && !state_reg.trunc) begin
                // Recovery counted from burst end, in CK cycles
                state_next.pre_run  = 1'b1;
                state_next.pre_cnt  = state_reg.recovery_setting_field;
                state_next.pre_bank = state_reg.cur_bank;
            end
            state_next.elem  = 4'h0;
            state_next.trunc = 1'b0;
            if (state_reg.pend) begin
                // Queued burst streams straight on
                state_next.cur_bank = state_reg.pend_bank;
                state_next.cur_col  = state_reg.pend_col;
                state_next.cur_ap   = state_reg.pend_ap;
                state_next.cur_len8 = state_reg.pend_len8;
                state_next.pend     = 1'b0;
            end else begin
                // Nothing queued: strobe edges now fall on deaf ears
                state_next.active = 1'b0;
            end
        end

        // Command intake on CK rise
        if (ck_rise && state_reg.cmd_s[1]) begin
            state_next.since_cmd = 3'h0;
            if (!state_reg.active || (burst_end && !state_reg.pend)) begin
                state_next.active   = 1'b1;
                state_next.cur_bank = state_reg.bank_s[1];
                state_next.cur_col  = state_reg.col_s[1];
                state_next.cur_ap   = state_reg.ap_s[1];
                state_next.cur_len8 = state_reg.burst_length8;
                state_next.elem     = 4'h0;
                state_next.trunc    = 1'b0;
                state_next.wl_cnt   = write_latency - 3'h1;
            end else if (!state_reg.pend) begin
                state_next.pend      = 1'b1;
                state_next.pend_bank = state_reg.bank_s[1];
                state_next.pend_col  = state_reg.col_s[1];
                state_next.pend_ap   = state_reg.ap_s[1];
                state_next.pend_len8 = state_reg.burst_length8;
                // Cut only a long burst without auto precharge, 2 CK on
                state_next.trunc = state_reg.cur_len8 &&
                    !state_reg.cur_ap &&
                    state_reg.since_cmd + 3'h1 == TRUNC_SPACING;
            end
        end

        // Row close after recovery; zero setting still waits one CK
        if (ck_rise && state_reg.pre_run) begin
            if (state_reg.pre_cnt <= 3'h1) begin
                state_next.pre_run    = 1'b0;
                state_next.close      = 1'b1;
                state_next.close_bank = state_reg.pre_bank;
            end else begin
                state_next.pre_cnt = state_reg.pre_cnt - 3'h1;
            end
        end

        // Register writes
        if (REG_WR_IN && REG_ADDR_IN == CONFIG_OFFSET) begin
            state_next.cas_latency =
                REG_WDATA_IN[CAS_MSB:CAS_LSB];
            state_next.burst_length8 = REG_WDATA_IN[BL8_BIT];
            state_next.recovery_setting_field =
                REG_WDATA_IN[RECOVERY_MSB:RECOVERY_LSB];
        end

        // Register reads, data one cycle later
        state_next.rdata = '0;
        if (REG_RD_IN) begin
            unique case (REG_ADDR_IN)
                CONFIG_OFFSET: begin
                    state_next.rdata[CAS_MSB:CAS_LSB] =
                        state_reg.cas_latency;
                    state_next.rdata[BL8_BIT] = state_reg.burst_length8;
                    state_next.rdata[RECOVERY_MSB:RECOVERY_LSB] =
                        state_reg.recovery_setting_field;
                end
                STATUS_OFFSET: begin
                    state_next.rdata[ST_ACTIVE_BIT]  = state_reg.active;
                    state_next.rdata[ST_PENDING_BIT] = state_reg.pend;
                    state_next.rdata[ST_PRECH_BIT]   = state_reg.pre_run;
                    state_next.rdata[ST_ELEM_MSB:ST_ELEM_LSB] =
                        state_reg.elem;
                end
                LAST_DATA_OFFSET: begin
                    state_next.rdata[DATA_WIDTH-1:0] = state_reg.last_data;
                end
                CAPTURE_CNT_OFFSET: begin
                    state_next.rdata[15:0] = state_reg.cap_count;
                end
                default: begin
                    state_next.rdata = '0;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            state_reg <= '0;
            state_reg.cas_latency <= CAS_RESET;
            state_reg.burst_length8 <= BL8_RESET;
            state_reg.recovery_setting_field <= RECOVERY_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign REG_RDATA_OUT      = state_reg.rdata;
    assign DATA_OUT           = state_reg.data;
    assign DATA_VALID_OUT     = state_reg.data_valid;
    assign DATA_BANK_OUT      = state_reg.data_bank;
    assign DATA_COLUMN_OUT    = state_reg.data_col;
    assign ROW_CLOSE_OUT      = state_reg.close;
    assign ROW_CLOSE_BANK_OUT = state_reg.close_bank;

endmodule // ddr2_write_burst

// [ddr2_write_burst_pkg.sv]
package ddr2_write_burst_pkg;

    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam int          REG_ADDR_WIDTH     = 8;
    localparam int          REG_DATA_WIDTH     = 32;
    localparam logic [7:0]  CONFIG_OFFSET      = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET      = 8'h04;
    localparam logic [7:0]  LAST_DATA_OFFSET   = 8'h08;
    localparam logic [7:0]  CAPTURE_CNT_OFFSET = 8'h0c;

    // --------------------------------------------------------------
    // Config field positions
    // --------------------------------------------------------------
    localparam int CAS_LSB      = 0;
    localparam int CAS_MSB      = 2;
    localparam int BL8_BIT      = 3;
    localparam int RECOVERY_LSB = 4;
    localparam int RECOVERY_MSB = 6;

    // --------------------------------------------------------------
    // Status field positions
    // --------------------------------------------------------------
    localparam int ST_ACTIVE_BIT   = 0;
    localparam int ST_PENDING_BIT  = 1;
    localparam int ST_PRECH_BIT    = 2;
    localparam int ST_ELEM_LSB     = 4;
    localparam int ST_ELEM_MSB     = 7;

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [2:0] CAS_RESET      = 3'h3;
    localparam logic       BL8_RESET      = 1'b0;
    localparam logic [2:0] RECOVERY_RESET = 3'h3;

    // --------------------------------------------------------------
    // Burst geometry in data elements, latency and command spacing in CK cycles
    // --------------------------------------------------------------
    localparam logic [3:0] BURST_SHORT     = 4'h4;
    localparam logic [3:0] BURST_LONG      = 4'h8;
    localparam logic [3:0] PREFETCH_ELEMS  = 4'h4;
    localparam logic [2:0] WRITE_LAT_DELTA = 3'h1;
    localparam logic [2:0] TRUNC_SPACING   = 3'h2;

endpackage

// [ddr2_write_burst_props.sv]
module ddr2_write_burst_props #(
    parameter int DATA_WIDTH = 8,
    parameter int BANK_WIDTH = 3
) (
    // Clock and reset
    input  wire logic                  CLK_IN,
    input  wire logic                  SYS_RST_IN,
    // Watched pins
    input  wire logic                  STROBE_IN,
    input  wire logic                  DQ_OE_OUT,
    input  wire logic [DATA_WIDTH-1:0] DATA_OUT,
    input  wire logic                  DATA_VALID_OUT,
    input  wire logic                  ROW_CLOSE_OUT,
    input  wire logic [BANK_WIDTH-1:0] ROW_CLOSE_BANK_OUT
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       strobe_d_reg;
    logic [3:0] edge_age_reg;
    logic [3:0] cap_age_reg;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // Saturating ages let one compare stand for a whole window
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            strobe_d_reg <= 1'b0;
            edge_age_reg <= 4'hf;
            cap_age_reg  <= 4'hf;
        end else begin
            strobe_d_reg <= STROBE_IN;
            edge_age_reg <= (STROBE_IN != strobe_d_reg) ? 4'h0 :
                edge_age_reg + {3'h0, edge_age_reg != 4'hf};
            cap_age_reg  <= DATA_VALID_OUT ? 4'h0 :
                cap_age_reg + {3'h0, cap_age_reg != 4'hf};
        end
    end
    sequence no_capture3;
        !DATA_VALID_OUT [*3];
    endsequence
    sequence strobe_still8;
        !$changed(STROBE_IN) [*8];
    endsequence
    chk_never_drives: assert property (!DQ_OE_OUT)
        else $error("data pins driven");
    chk_capture_gap: assert property (DATA_VALID_OUT |=> no_capture3)
        else $error("captures closer than a strobe half period");
    chk_capture_cause: assert property (
        DATA_VALID_OUT |-> edge_age_reg <= 4'h5)
        else $error("capture without a recent strobe edge");
    chk_idle_ignored: assert property (
        strobe_still8 |-> !DATA_VALID_OUT)
        else $error("capture while strobe idle");
    chk_data_holds: assert property (
        !DATA_VALID_OUT |-> $stable(DATA_OUT))
        else $error("captured data moved without capture");
    chk_close_pulse: assert property (ROW_CLOSE_OUT |=> !ROW_CLOSE_OUT)
        else $error("row close longer than one cycle");
    chk_close_bank: assert property (
        $changed(ROW_CLOSE_BANK_OUT) |-> ROW_CLOSE_OUT)
        else $error("closed bank moved without close");
    chk_close_late: assert property (
        ROW_CLOSE_OUT |-> cap_age_reg >= 4'h2)
        else $error("row closed before burst end");
endmodule // ddr2_write_burst_props

bind ddr2_write_burst ddr2_write_burst_props #(
    .DATA_WIDTH(DATA_WIDTH),
    .BANK_WIDTH(BANK_WIDTH)
) u_props (
    .CLK_IN(CLK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .STROBE_IN(STROBE_IN),
    .DQ_OE_OUT(DQ_OE_OUT),
    .DATA_OUT(DATA_OUT),
    .DATA_VALID_OUT(DATA_VALID_OUT),
    .ROW_CLOSE_OUT(ROW_CLOSE_OUT),
    .ROW_CLOSE_BANK_OUT(ROW_CLOSE_BANK_OUT)
);

// [ddr2_ctrl_model.sv]
module ddr2_ctrl_model #(
    parameter int DATA_WIDTH = 8,
    parameter int BANK_WIDTH = 3,
    parameter int COL_WIDTH  = 10
) (
    // Command side
    output logic                  ck_out,
    output logic                  cmd_out,
    output logic                  ap_out,
    output logic [BANK_WIDTH-1:0] bank_out,
    output logic [COL_WIDTH-1:0]  col_out,
    // Data side
    output logic                  strobe_out,
    output logic [DATA_WIDTH-1:0] dq_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // Free running, phase kept off the system clock edges
    initial begin
        {ck_out, cmd_out, ap_out, strobe_out, bank_out, col_out, dq_out} = '0;
        #3;
        forever #40 ck_out = ~ck_out;
    end
    // Only writes are issued, never reads or precharges
    task automatic write_burst(input int skip, input int wl, input int n,
                               input logic ap, input logic [BANK_WIDTH-1:0] b,
                               input logic [COL_WIDTH-1:0] c,
                               input logic [DATA_WIDTH-1:0] d0);
        repeat (skip + 1) @(negedge ck_out);
        cmd_out = 1'b1;
        {ap_out, bank_out, col_out} = {ap, b, c};
        @(negedge ck_out);
        cmd_out = 1'b0;
        // Released address lines show garbage, not the last value
        {ap_out, bank_out, col_out} = ~{ap, b, c};
        // Strobe stays low as preamble until the latency is met
        repeat (wl - 1) @(negedge ck_out);
        // Data leads each strobe edge by a quarter period
        for (int i = 0; i < n; i++) begin
            #20 dq_out = d0 + DATA_WIDTH'(i);
            #20 strobe_out = ~strobe_out;
        end
        #10 dq_out = ~dq_out;
    endtask
    // Stray strobe edges and data with no write pending
    task automatic stray();
        @(negedge ck_out);
        repeat (2) begin
            #20 dq_out = ~dq_out;
            #20 strobe_out = ~strobe_out;
        end
    endtask
endmodule // ddr2_ctrl_model

// [ddr2_write_burst_tb.sv]
module ddr2_write_burst_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ddr2_write_burst_pkg::*;
    logic        clk, rst, reg_wr, reg_rd, ck, cmd, ap, strobe;
    logic        valid, dq_oe, row_close;
    logic [7:0]  reg_addr, dq, ddata, dq_drv;
    logic [31:0] reg_wdata, reg_rdata;
    logic [2:0]  bank, dbank, close_bank;
    logic [9:0]  col, dcol;
    logic [31:0] cap_q[$];
    logic [31:0] close_q[$];
    int          err_count = 0, cmp_count = 0, cyc = 0;
    int          last_cap = 0, close_at = 0;
    ddr2_write_burst u_dut (.CLK_IN(clk), .SYS_RST_IN(rst),
        .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr),
        .REG_RD_IN(reg_rd), .REG_RDATA_OUT(reg_rdata), .CK_IN(ck),
        .WRITE_CMD_IN(cmd), .AUTO_PRECHARGE_IN(ap), .BANK_IN(bank),
        .COLUMN_IN(col), .STROBE_IN(strobe), .DQ_IN(dq), .DQ_OUT(dq_drv),
        .DQ_OE_OUT(dq_oe), .DATA_OUT(ddata), .DATA_VALID_OUT(valid),
        .DATA_BANK_OUT(dbank), .DATA_COLUMN_OUT(dcol),
        .ROW_CLOSE_OUT(row_close), .ROW_CLOSE_BANK_OUT(close_bank));
    ddr2_ctrl_model u_ctrl (.ck_out(ck), .cmd_out(cmd), .ap_out(ap),
        .bank_out(bank), .col_out(col), .strobe_out(strobe), .dq_out(dq));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (valid === 1'b1) begin
            cap_q.push_back({11'h0, dbank, dcol, ddata});
            last_cap = cyc;
        end
        if (row_close === 1'b1) begin
            close_q.push_back({29'h0, close_bank});
            close_at = cyc;
        end
    end
    function automatic logic [31:0] cfg(input logic [2:0] cas,
                                        input logic bl8, input logic [2:0] r);
        return (32'(cas) << CAS_LSB) | (32'(bl8) << BL8_BIT) |
               (32'(r) << RECOVERY_LSB);
    endfunction
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check("register read", reg_rdata, exp);
    endtask
    task automatic settle(input int n);
        int k;
        k = 0;
        while (cap_q.size() < n && k < 800) begin
            @(posedge clk);
            k++;
        end
        repeat (48) @(posedge clk);
        check("capture count", 32'(cap_q.size()), 32'(n));
    endtask
    task automatic burst_is(input logic [2:0] b, input logic [9:0] c,
                            input logic [7:0] d0, input int n);
        for (int i = 0; i < n; i++) begin
            check("element", cap_q.size() > 0 ? cap_q.pop_front() : 32'hx,
                  {11'h0, b, c + 10'(i), d0 + 8'(i)});
        end
    endtask
    task automatic close_is(input logic [2:0] b, input int r);
        check("closed bank", close_q.size() == 1 ? close_q.pop_front() : 32'hx,
              {29'h0, b});
        check("recovery", 32'((close_at - last_cap) / 8), 32'(r - 1));
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 42'h0};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        reg_check(CONFIG_OFFSET, cfg(CAS_RESET, BL8_RESET, RECOVERY_RESET));
        reg_write(CONFIG_OFFSET, cfg(3'h4, 1'b1, 3'h7));
        reg_check(CONFIG_OFFSET, cfg(3'h4, 1'b1, 3'h7));
        reg_write(STATUS_OFFSET, 32'hffff_ffff);
        reg_check(STATUS_OFFSET, 32'h0);
        reg_write(8'h40, 32'hffff_ffff);
        reg_check(8'h40, 32'h0);
        $display("test registers finished");
        reg_write(CONFIG_OFFSET, cfg(3'h3, 1'b0, 3'h3));
        u_ctrl.write_burst(0, 2, 4, 1'b0, 3'h2, 10'h010, 8'ha0);
        settle(4);
        burst_is(3'h2, 10'h010, 8'ha0, 4);
        check("no close", 32'(close_q.size()), 32'h0);
        fork
            u_ctrl.write_burst(0, 2, 4, 1'b0, 3'h1, 10'h100, 8'h00);
            u_ctrl.write_burst(2, 2, 4, 1'b0, 3'h4, 10'h204, 8'h40);
        join
        settle(8);
        burst_is(3'h1, 10'h100, 8'h00, 4);
        burst_is(3'h4, 10'h204, 8'h40, 4);
        $display("test single and streamed finished");
        reg_write(CONFIG_OFFSET, cfg(3'h3, 1'b1, 3'h2));
        fork
            u_ctrl.write_burst(0, 2, 4, 1'b0, 3'h3, 10'h020, 8'h10);
            u_ctrl.write_burst(2, 2, 8, 1'b1, 3'h5, 10'h040, 8'h30);
        join
        settle(12);
        burst_is(3'h3, 10'h020, 8'h10, 4);
        burst_is(3'h5, 10'h040, 8'h30, 8);
        close_is(3'h5, 2);
        reg_write(CONFIG_OFFSET, cfg(3'h3, 1'b0, 3'h5));
        u_ctrl.write_burst(0, 2, 4, 1'b1, 3'h6, 10'h3f8, 8'hc0);
        settle(4);
        burst_is(3'h6, 10'h3f8, 8'hc0, 4);
        close_is(3'h6, 5);
        $display("test truncation and recovery finished");
        reg_write(CONFIG_OFFSET, cfg(3'h4, 1'b0, 3'h3));
        u_ctrl.write_burst(0, 3, 4, 1'b0, 3'h1, 10'h155, 8'h5c);
        settle(4);
        burst_is(3'h1, 10'h155, 8'h5c, 4);
        u_ctrl.stray();
        settle(0);
        check("pin enable", {31'h0, dq_oe}, 32'h0);
        check("pin drive", {24'h0, dq_drv}, 32'h0);
        reg_check(CAPTURE_CNT_OFFSET, 32'h20);
        reg_check(LAST_DATA_OFFSET, 32'h5f);
        $display("test latency and idle finished");
        stop_test();
    end
    initial begin
        #100000;
        err_count++;
        stop_test();
    end
endmodule // ddr2_write_burst_tb
